//--- logic/log_mem.sv
// Small record memory with registered read data
`timescale 1ns/100ps
module log_mem #(
  parameter int W = 128,
  parameter int DEPTH = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem [DEPTH];

  // Array carries no reset, only the read port does
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

//--- logic/prog_stage.sv
// Programmable protection stage: blocking, status, events, counters, log
`timescale 1ns/100ps
module prog_stage #(
  parameter int TICK_CYCLES = prog_stage_pkg::PROC_CYCLE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic blk_in,
  input wire logic signed [31:0] meas_in,
  input wire logic [2:0] grp_in,
  output logic start_o,
  output logic trip_o,
  output logic blocked_o,
  output logic evt_valid,
  output logic [2:0] evt_code,
  output logic [31:0] evt_stamp,
  output logic irq
);
  import prog_stage_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  typedef enum {ST_NORMAL, ST_START, ST_RELEASE, ST_TRIP, ST_BLOCKED} stage_state_e;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic blk_s1_r, blk_s2_r;
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  logic [31:0] ms_r, ms_nxt;
  logic [4:0] win_r, win_nxt;
  logic signed [47:0] ref_r, ref_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_acc;
  logic [2:0] mode_r, mode_nxt;
  logic [31:0] set_r, set_nxt, blklim_r, blklim_nxt;
  logic [15:0] hyst_r, hyst_nxt;
  logic [20:0] opdly_r, opdly_nxt, reldly_r, reldly_nxt;
  logic [5:0] evcfg_r, evcfg_nxt, mask_r, mask_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic signed [47:0] meas_x, set_x, set_abs, diff, ref_abs, pct, x, h_amt;
  logic under, cmp_ok, pk_cand;
  stage_state_e st_r, st_nxt;
  logic [20:0] tmr_r, tmr_nxt, rel_r, rel_nxt;
  logic pk_r, pk_nxt, blk_smp_r, blk_smp_nxt;
  logic start_r, start_nxt, trip_r, trip_nxt, blocked_r, blocked_nxt;
  logic [EV_NUM-1:0] ev;
  logic [EV_NUM-1:0] pend_r, pend_nxt;
  logic [31:0] stamp_r, stamp_nxt;
  logic evt_valid_r, evt_valid_nxt;
  logic [2:0] evt_code_r, evt_code_nxt;
  logic [15:0] cnt_r [3];
  logic [15:0] cnt_nxt [3];
  logic [5:0] ist_r, ist_nxt;
  logic irq_r, irq_nxt;
  logic [3:0] wp_r, wp_nxt, nlog_r, nlog_nxt;
  logic rec_wr;
  logic [1:0] rec_evt;
  logic [20:0] remain;
  logic signed [47:0] ratio;
  logic [LOG_W-1:0] rec_data, rd_data;
  logic [3:0] rd_addr, log_wa;

  //////////////////////////////////////////////////////////////////////////////
  // Blocking pin synchroniser; only the second stage is read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blk_s1_r <= 1'b0;
      blk_s2_r <= 1'b0;
    end else begin
      blk_s1_r <= blk_in;
      blk_s2_r <= blk_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Processing cycle, ms time base and 20 ms delta reference
  assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));

  always_comb begin
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
    ms_nxt = tick ? ms_r + 32'h1 : ms_r;
    win_nxt = win_r;
    ref_nxt = ref_r;
    if (tick) begin
      if (win_r == 5'(DELTA_WIN_MS - 1)) begin
        win_nxt = '0;
        ref_nxt = meas_x;
      end else begin
        win_nxt = win_r + 5'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
      ms_r <= '0;
      win_r <= '0;
      ref_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      ms_r <= ms_nxt;
      win_r <= win_nxt;
      ref_r <= ref_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pick-up comparator with hysteresis and under-mode blocking limit
  always_comb begin
    meas_x = 48'(meas_in);
    set_x = 48'($signed(set_r));
    set_abs = set_x[47] ? -set_x : set_x;
    h_amt = $signed((set_abs * 48'(hyst_r)) / 48'(HYST_SCALE));
    diff = meas_x - ref_r;
    ref_abs = ref_r[47] ? -ref_r : ref_r;
    pct = (ref_abs == 0) ? 48'sd0 : (diff * 48'(PCT_SCALE)) / ref_abs;
    x = meas_x;
    under = 1'b0;
    unique case (cmp_mode_e'(mode_r))
      M_OVER: x = meas_x;
      M_OVER_ABS: x = meas_x[47] ? -meas_x : meas_x;
      M_UNDER: under = 1'b1;
      M_UNDER_ABS: begin
        x = meas_x[47] ? -meas_x : meas_x;
        under = 1'b1;
      end
      M_DPCT_DIR: begin
        x = pct;
        under = set_x[47];
      end
      M_DPCT_ABS: x = pct[47] ? -pct : pct;
      M_DVAL_DIR: begin
        x = diff;
        under = set_x[47];
      end
      M_DVAL_ABS: x = diff[47] ? -diff : diff;
    endcase
    // Below the limit a dead input would look like a deep undervalue
    cmp_ok = !((mode_r == M_UNDER || mode_r == M_UNDER_ABS) &&
               (meas_x < 48'($signed(blklim_r))));
    if (under) begin
      pk_cand = pk_r ? (x < set_x + h_amt) : (x < set_x);
    end else begin
      pk_cand = pk_r ? (x > set_x - h_amt) : (x > set_x);
    end
    pk_cand = pk_cand && cmp_ok;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stage state, evaluated once per processing cycle
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    rel_nxt = rel_r;
    pk_nxt = pk_r;
    blk_smp_nxt = blk_smp_r;
    if (tick) begin
      blk_smp_nxt = blk_s2_r;
      pk_nxt = pk_cand;
      unique case (st_r)
        ST_NORMAL: begin
          tmr_nxt = '0;
          if (pk_cand) begin
            st_nxt = blk_s2_r ? ST_BLOCKED : ST_START;
          end
        end
        ST_START: begin
          if (blk_s2_r || !pk_cand) begin
            st_nxt = ST_RELEASE;
            rel_nxt = '0;
          end else if (tmr_r + 21'h1 >= opdly_r) begin
            st_nxt = ST_TRIP;
            tmr_nxt = opdly_r;
          end else begin
            tmr_nxt = tmr_r + 21'h1;
          end
        end
        ST_RELEASE: begin
          if (pk_cand && !blk_s2_r) begin
            st_nxt = ST_START;
          end else if (rel_r + 21'h1 >= reldly_r) begin
            st_nxt = ST_NORMAL;
            tmr_nxt = '0;
          end else begin
            rel_nxt = rel_r + 21'h1;
          end
        end
        ST_TRIP: begin
          if (!pk_cand) begin
            st_nxt = ST_NORMAL;
            tmr_nxt = '0;
          end
        end
        ST_BLOCKED: begin
          if (!pk_cand) begin
            st_nxt = ST_NORMAL;
          end
        end
      endcase
    end
    start_nxt = (st_nxt == ST_START) || (st_nxt == ST_TRIP);
    trip_nxt = (st_nxt == ST_TRIP);
    blocked_nxt = (st_nxt == ST_BLOCKED);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_NORMAL;
      tmr_r <= '0;
      rel_r <= '0;
      pk_r <= 1'b0;
      blk_smp_r <= 1'b0;
      start_r <= 1'b0;
      trip_r <= 1'b0;
      blocked_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      rel_r <= rel_nxt;
      pk_r <= pk_nxt;
      blk_smp_r <= blk_smp_nxt;
      start_r <= start_nxt;
      trip_r <= trip_nxt;
      blocked_r <= blocked_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge events and event-buffer output, one event per clock
  assign ev = {!blocked_nxt && blocked_r, blocked_nxt && !blocked_r,
               !trip_nxt && trip_r, trip_nxt && !trip_r,
               !start_nxt && start_r, start_nxt && !start_r};

  always_comb begin
    pend_nxt = pend_r;
    evt_valid_nxt = 1'b0;
    evt_code_nxt = evt_code_r;
    for (int i = EV_NUM - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        evt_valid_nxt = 1'b1;
        evt_code_nxt = 3'(i);
      end
    end
    if (evt_valid_nxt) begin
      pend_nxt[evt_code_nxt] = 1'b0;
    end
    // New edges win over the bit just sent
    pend_nxt = pend_nxt | (ev & evcfg_r);
    stamp_nxt = (|ev) ? ms_r : stamp_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
      stamp_r <= '0;
      evt_valid_r <= 1'b0;
      evt_code_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      stamp_r <= stamp_nxt;
      evt_valid_r <= evt_valid_nxt;
      evt_code_r <= evt_code_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counters, interrupt status and record log pointers
  assign wr_acc = avs_write && !wait_r;
  assign rec_wr = ev[EV_START_ON] | ev[EV_TRIP_ON] | ev[EV_BLK_ON];
  assign rec_evt = ev[EV_BLK_ON] ? 2'h2 : (ev[EV_TRIP_ON] ? 2'h1 : 2'h0);
  assign remain = (st_nxt == ST_START) ? opdly_r - tmr_nxt : '0;
  assign ratio = (set_x == 0) ? 48'sd0 : (meas_x * 48'(RATIO_SCALE)) / set_x;
  assign rec_data = {6'h0, grp_in, rec_evt, remain, 32'(ratio), meas_in, ms_r};
  assign rd_addr = 4'((int'(wp_r) + 2 * LOG_DEPTH - 1 - int'(sel_r)) % LOG_DEPTH);

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cnt_nxt[i] = cnt_r[i];
      if (wr_acc && avs_address == REG_CMD && avs_writedata[CMD_CLR_CNT]) begin
        cnt_nxt[i] = '0;
      end
      cnt_nxt[i] = cnt_nxt[i] + 16'(ev[2 * i]);
    end
    ist_nxt = ist_r;
    if (wr_acc && avs_address == REG_IRQ_STAT) begin
      ist_nxt = ist_r & ~avs_writedata[5:0];
    end
    ist_nxt = ist_nxt | ev;
    irq_nxt = |(ist_nxt & mask_nxt);
    wp_nxt = wp_r;
    nlog_nxt = nlog_r;
    if (wr_acc && avs_address == REG_CMD && avs_writedata[CMD_CLR_LOG]) begin
      wp_nxt = '0;
      nlog_nxt = '0;
    end
    // A record in the clear cycle lands in slot 0 and survives the clear
    log_wa = wp_nxt;
    if (rec_wr) begin
      wp_nxt = (log_wa == 4'(LOG_DEPTH - 1)) ? '0 : log_wa + 4'h1;
      nlog_nxt = (nlog_nxt == 4'(LOG_DEPTH)) ? nlog_nxt : nlog_nxt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        cnt_r[i] <= '0;
      end
      ist_r <= '0;
      irq_r <= 1'b0;
      wp_r <= '0;
      nlog_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      ist_r <= ist_nxt;
      irq_r <= irq_nxt;
      wp_r <= wp_nxt;
      nlog_r <= nlog_nxt;
    end
  end

  log_mem #(.W(LOG_W), .DEPTH(LOG_DEPTH)) u_log (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(rec_wr),
    .wr_addr(log_wa),
    .wr_data(rec_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, write lands when waitrequest is low
  always_comb begin
    wait_nxt = !((avs_read || avs_write) && wait_r);
    mode_nxt = mode_r;
    set_nxt = set_r;
    hyst_nxt = hyst_r;
    blklim_nxt = blklim_r;
    opdly_nxt = opdly_r;
    reldly_nxt = reldly_r;
    evcfg_nxt = evcfg_r;
    mask_nxt = mask_r;
    sel_nxt = sel_r;
    if (wr_acc) begin
      unique case (avs_address)
        REG_MODE: mode_nxt = avs_writedata[2:0];
        REG_PICKUP: set_nxt = avs_writedata;
        REG_HYST: hyst_nxt = avs_writedata[15:0];
        REG_BLKLIM: blklim_nxt = avs_writedata;
        REG_OPDLY: opdly_nxt = avs_writedata[20:0];
        REG_RELDLY: reldly_nxt = avs_writedata[20:0];
        REG_EVCFG: evcfg_nxt = avs_writedata[5:0];
        REG_IRQ_MASK: mask_nxt = avs_writedata[5:0];
        REG_LOG_SEL: begin
          // Out-of-range index is held at the oldest slot
          sel_nxt = (avs_writedata[3:0] > 4'(LOG_DEPTH - 1)) ?
                    4'(LOG_DEPTH - 1) : avs_writedata[3:0];
        end
        default: ;
      endcase
    end
    rdata_nxt = rdata_r;
    if (avs_read && wait_r) begin
      rdata_nxt = '0;
      unique case (avs_address)
        REG_MODE: rdata_nxt = 32'(mode_r);
        REG_PICKUP: rdata_nxt = set_r;
        REG_HYST: rdata_nxt = 32'(hyst_r);
        REG_BLKLIM: rdata_nxt = blklim_r;
        REG_OPDLY: rdata_nxt = 32'(opdly_r);
        REG_RELDLY: rdata_nxt = 32'(reldly_r);
        REG_EVCFG: rdata_nxt = 32'(evcfg_r);
        REG_STATUS: rdata_nxt = 32'({pk_r, blk_smp_r, blocked_r, trip_r, start_r});
        REG_REMAIN: rdata_nxt = (st_r == ST_START) ? 32'(opdly_r - tmr_r) : '0;
        REG_IRQ_STAT: rdata_nxt = 32'(ist_r);
        REG_IRQ_MASK: rdata_nxt = 32'(mask_r);
        REG_CNT_START: rdata_nxt = 32'(cnt_r[0]);
        REG_CNT_TRIP: rdata_nxt = 32'(cnt_r[1]);
        REG_CNT_BLK: rdata_nxt = 32'(cnt_r[2]);
        REG_LOG_SEL: rdata_nxt = 32'({nlog_r, 4'h0, sel_r});
        REG_LOG0: rdata_nxt = rd_data[31:0];
        5'h11: rdata_nxt = rd_data[63:32];
        5'h12: rdata_nxt = rd_data[95:64];
        REG_LOG3: rdata_nxt = rd_data[127:96];
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
      mode_r <= MODE_RST;
      set_r <= PICKUP_RST;
      hyst_r <= HYST_RST;
      blklim_r <= BLKLIM_RST;
      opdly_r <= OPDLY_RST;
      reldly_r <= RELDLY_RST;
      evcfg_r <= EVCFG_RST;
      mask_r <= MASK_RST;
      sel_r <= '0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      mode_r <= mode_nxt;
      set_r <= set_nxt;
      hyst_r <= hyst_nxt;
      blklim_r <= blklim_nxt;
      opdly_r <= opdly_nxt;
      reldly_r <= reldly_nxt;
      evcfg_r <= evcfg_nxt;
      mask_r <= mask_nxt;
      sel_r <= sel_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign start_o = start_r;
  assign trip_o = trip_r;
  assign blocked_o = blocked_r;
  assign evt_valid = evt_valid_r;
  assign evt_code = evt_code_r;
  assign evt_stamp = stamp_r;
  assign irq = irq_r;

endmodule

//--- logic/prog_stage_pkg.sv
// Constants, register map and types shared by the programmable stage design
package prog_stage_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing and scale factors
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROC_CYCLE_NS = 1000000;
  localparam int PROC_CYCLE_CYC = PROC_CYCLE_NS / CLK_PERIOD_NS;
  localparam int DELTA_WIN_MS = 20;
  localparam int BLK_LEAD_MS = 5;
  localparam int TRIP_REM_MAX_MS = 1800000;
  localparam int HYST_SCALE = 1000;
  localparam int PCT_SCALE = 100;
  localparam int RATIO_SCALE = 1000;

  //////////////////////////////////////////////////////////////////////////////
  // Record log
  localparam int LOG_DEPTH = 12;
  localparam int LOG_W = 128;
  localparam int REC_REM_LSB = 0;
  localparam int REC_EVT_LSB = 21;
  localparam int REC_GRP_LSB = 23;

  //////////////////////////////////////////////////////////////////////////////
  // Register word indices (byte address is four times the index)
  localparam logic [4:0] REG_MODE = 5'h00;
  localparam logic [4:0] REG_PICKUP = 5'h01;
  localparam logic [4:0] REG_HYST = 5'h02;
  localparam logic [4:0] REG_BLKLIM = 5'h03;
  localparam logic [4:0] REG_OPDLY = 5'h04;
  localparam logic [4:0] REG_RELDLY = 5'h05;
  localparam logic [4:0] REG_EVCFG = 5'h06;
  localparam logic [4:0] REG_STATUS = 5'h07;
  localparam logic [4:0] REG_REMAIN = 5'h08;
  localparam logic [4:0] REG_IRQ_STAT = 5'h09;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0a;
  localparam logic [4:0] REG_CNT_START = 5'h0b;
  localparam logic [4:0] REG_CNT_TRIP = 5'h0c;
  localparam logic [4:0] REG_CNT_BLK = 5'h0d;
  localparam logic [4:0] REG_CMD = 5'h0e;
  localparam logic [4:0] REG_LOG_SEL = 5'h0f;
  localparam logic [4:0] REG_LOG0 = 5'h10;
  localparam logic [4:0] REG_LOG3 = 5'h13;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and field positions
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [31:0] PICKUP_RST = 32'h00000001;
  localparam logic [15:0] HYST_RST = 16'h001e;
  localparam logic [31:0] BLKLIM_RST = 32'h00000000;
  localparam logic [20:0] OPDLY_RST = 21'h000028;
  localparam logic [20:0] RELDLY_RST = 21'h00003c;
  localparam logic [5:0] EVCFG_RST = 6'h3f;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam int CMD_CLR_CNT = 0;
  localparam int CMD_CLR_LOG = 1;
  localparam int LOG_CNT_LSB = 8;

  // Event indices: ON at even, OFF at odd positions
  localparam int EV_START_ON = 0;
  localparam int EV_TRIP_ON = 2;
  localparam int EV_BLK_ON = 4;
  localparam int EV_NUM = 6;

  typedef enum logic [2:0] {
    M_OVER, M_OVER_ABS, M_UNDER, M_UNDER_ABS,
    M_DPCT_DIR, M_DPCT_ABS, M_DVAL_DIR, M_DVAL_ABS
  } cmp_mode_e;

endpackage

//--- tb/prog_stage_assertions.sv
// Concurrent checks on the programmable stage ports
`timescale 1ns/100ps
module prog_stage_assertions #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic start_o,
  input wire logic trip_o,
  input wire logic blocked_o,
  input wire logic evt_valid,
  input wire logic [2:0] evt_code
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake steps
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  AST_BUS_ANSWER: assert property (s_taken |=> s_answer)
    else $error("bus answer not after exactly one wait cycle");
  AST_BUS_IDLE: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");

  //////////////////////////////////////////////////////////////////////////////
  // Stage states: change only on ticks, so no change may follow within 8 clocks
  AST_TICK_PACE: assert property ($changed({start_o, trip_o, blocked_o}) |=>
    $stable({start_o, trip_o, blocked_o})[*8]) else $error("state changed between ticks");
  AST_TRIP_HAS_START: assert property (trip_o |-> start_o)
    else $error("trip without start");
  AST_BLK_ALONE: assert property (blocked_o |-> !start_o && !trip_o)
    else $error("blocked together with start or trip");

  //////////////////////////////////////////////////////////////////////////////
  // Events follow the state edges
  AST_TRIP_EVENT: assert property ($rose(trip_o) |-> ##[1:8] (evt_valid && evt_code == 3'h2))
    else $error("no trip on event");
  AST_BLK_EVENT: assert property ($rose(blocked_o) |-> ##[1:8] (evt_valid && evt_code == 3'h4))
    else $error("no block on event");
  AST_START_ON_EVT: assert property (evt_valid && evt_code == 3'h0 |-> start_o)
    else $error("start on event while start low");
  AST_START_OFF_EVT: assert property (evt_valid && evt_code == 3'h1 |-> !start_o)
    else $error("start off event while start high");
endmodule

//--- tb/stage_partner.sv
// Blocking matrix and event buffer model facing the stage
`timescale 1ns/100ps
module stage_partner (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic blk_req,
  output logic blk_in,
  input wire logic evt_valid,
  input wire logic [2:0] evt_code,
  input wire logic [31:0] evt_stamp,
  output logic [31:0] ev_count,
  output logic [31:0] st_last,
  output logic [31:0] st_prev,
  output logic [2:0] ev_last
);
  // Block line is registered; bench raises it ticks ahead of any operate delay
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blk_in <= 1'b0;
      ev_count <= 32'h0;
      st_last <= 32'h0;
      st_prev <= 32'h0;
      ev_last <= 3'h7;
    end else begin
      blk_in <= blk_req;
      // No ready: every pulse is taken, so losing one shows in the count
      if (evt_valid) begin
        ev_count <= ev_count + 32'h1;
        ev_last <= evt_code;
        st_prev <= st_last;
        st_last <= evt_stamp;
      end
    end
  end
endmodule

//--- tb/tb_prog_stage.sv
// Self-checking bench for the programmable protection stage
`timescale 1ns/100ps
module tb_prog_stage;
  import prog_stage_pkg::*;
  localparam int TK = 20;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, blk_req, blk_in;
  logic start_o, trip_o, blocked_o, evt_valid, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, evt_stamp, ev_count, st_last, st_prev, rd;
  logic signed [31:0] meas_in;
  logic [2:0] grp_in, evt_code, ev_last;
  int fails, n_tests;

  prog_stage #(.TICK_CYCLES(TK)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .blk_in(blk_in), .meas_in(meas_in), .grp_in(grp_in),
    .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .evt_valid(evt_valid),
    .evt_code(evt_code), .evt_stamp(evt_stamp), .irq(irq));
  stage_partner i_partner (.clk_sys(clk_sys), .rst_n(rst_n), .blk_req(blk_req), .blk_in(blk_in),
    .evt_valid(evt_valid), .evt_code(evt_code), .evt_stamp(evt_stamp), .ev_count(ev_count),
    .st_last(st_last), .st_prev(st_prev), .ev_last(ev_last));

  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic tick(input int n);
    repeat (n * TK) @(posedge clk_sys);
  endtask

  // Bounded wait for {start, trip, blocked}; a tick is 20 clocks
  task automatic wait_st(input logic [2:0] e);
    int n;
    n = 0;
    while ({start_o, trip_o, blocked_o} !== e && n < 6 * TK) begin
      @(posedge clk_sys);
      n++;
    end
    chk("status", {29'h0, start_o, trip_o, blocked_o}, {29'h0, e});
  endtask

  // Start then release; three idle ticks let the held timer return to zero
  task automatic pulse();
    meas_in <= 32'sd100;
    wait_st(3'b100);
    meas_in <= 32'sd0;
    wait_st(3'b000);
    tick(3);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_regs();
    logic [4:0] ad [12] = '{REG_MODE, REG_PICKUP, REG_HYST, REG_BLKLIM, REG_OPDLY, REG_RELDLY,
      REG_EVCFG, REG_IRQ_MASK, REG_CNT_START, REG_CNT_TRIP, REG_CNT_BLK, 5'h1f};
    logic [31:0] ev [12] = '{32'(MODE_RST), PICKUP_RST, 32'(HYST_RST), BLKLIM_RST,
      32'(OPDLY_RST), 32'(RELDLY_RST), 32'(EVCFG_RST), 32'(MASK_RST), 0, 0, 0, 0};
    for (int i = 0; i < 12; i++) begin
      rc("reset value", ad[i], ev[i]);
    end
    bus(1'b1, 5'h1f, 32'hffffffff);
    bus(1'b1, REG_OPDLY, 32'h3);
    bus(1'b1, REG_RELDLY, 32'h1);
    bus(1'b1, REG_IRQ_MASK, 32'h1);
    rc("unmapped", 5'h1f, 32'h0);
    rc("opdly", REG_OPDLY, 32'h3);
  endtask

  task automatic s_trip();
    meas_in <= 32'sd100;
    wait_st(3'b100);
    chk("irq up", {31'h0, irq}, 32'h1);
    repeat (4) @(posedge clk_sys);
    chk("start on code", {29'h0, ev_last}, 32'h0);
    wait_st(3'b110);
    repeat (4) @(posedge clk_sys);
    chk("trip delay stamp", st_last - st_prev, 32'h3);
    meas_in <= 32'sd0;
    wait_st(3'b000);
    repeat (8) @(posedge clk_sys);
    rc("event bits", REG_IRQ_STAT, 32'h0f);
    bus(1'b1, REG_IRQ_STAT, 32'h3f);
    rc("event bits clr", REG_IRQ_STAT, 32'h0);
    chk("irq down", {31'h0, irq}, 32'h0);
    rc("start count", REG_CNT_START, 32'h1);
    rc("trip count", REG_CNT_TRIP, 32'h1);
  endtask

  task automatic s_block();
    bus(1'b1, REG_IRQ_MASK, 32'h0);
    blk_req <= 1'b1;
    tick(2);
    meas_in <= 32'sd100;
    wait_st(3'b001);
    tick(5);
    wait_st(3'b001);
    chk("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h10);
    repeat (2) @(posedge clk_sys);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    bus(1'b1, REG_IRQ_STAT, 32'h3f);
    bus(1'b1, REG_IRQ_MASK, 32'h0);
    rc("blocked count", REG_CNT_BLK, 32'h1);
    blk_req <= 1'b0;
    meas_in <= 32'sd0;
    wait_st(3'b000);
    tick(3);
  endtask

  task automatic s_release();
    meas_in <= 32'sd100;
    wait_st(3'b100);
    blk_req <= 1'b1;
    tick(2);
    chk("start dropped", {31'h0, start_o}, 32'h0);
    tick(4);
    chk("no trip", {31'h0, trip_o}, 32'h0);
    blk_req <= 1'b0;
    meas_in <= 32'sd0;
    wait_st(3'b000);
    tick(3);
  endtask

  // Under mode: blocking limit, then hysteresis above the setting
  task automatic s_mode();
    bus(1'b1, REG_BLKLIM, 32'd10);
    bus(1'b1, REG_PICKUP, 32'd50);
    bus(1'b1, REG_MODE, 32'h2);
    tick(3);
    chk("under limit", {31'h0, start_o}, 32'h0);
    meas_in <= 32'sd40;
    wait_st(3'b100);
    meas_in <= 32'sd50;
    tick(2);
    chk("hyst hold", {31'h0, start_o}, 32'h1);
    meas_in <= 32'sd51;
    wait_st(3'b000);
    meas_in <= 32'sd0;
    bus(1'b1, REG_MODE, 32'h0);
    bus(1'b1, REG_PICKUP, 32'h1);
    tick(3);
  endtask

  task automatic s_evcfg();
    logic [31:0] n0;
    bus(1'b1, REG_EVCFG, 32'h3d);
    n0 = ev_count;
    pulse();
    chk("off muted", ev_count - n0, 32'h1);
    bus(1'b1, REG_EVCFG, 32'h3f);
    n0 = ev_count;
    pulse();
    chk("both edges", ev_count - n0, 32'h2);
  endtask

  task automatic s_log();
    logic [31:0] s0;
    bus(1'b1, REG_CMD, 32'h2);
    bus(1'b1, REG_CMD, 32'h1);
    rc("count cleared", REG_CNT_START, 32'h0);
    pulse();
    bus(1'b0, REG_LOG_SEL, 32'h0);
    chk("held one", {28'h0, rd[11:8]}, 32'h1);
    repeat (12) pulse();
    bus(1'b0, REG_LOG_SEL, 32'h0);
    chk("held full", {28'h0, rd[11:8]}, 32'hc);
    rc("start count", REG_CNT_START, 32'hd);
    bus(1'b1, REG_LOG_SEL, 32'h0);
    repeat (2) @(posedge clk_sys);
    bus(1'b0, REG_LOG0, 32'h0);
    s0 = rd;
    rc("rec magnitude", 5'h11, 32'd100);
    bus(1'b0, REG_LOG3, 32'h0);
    chk("rec group event", {27'h0, rd[25:21]}, {27'h0, 3'h5, 2'h0});
    bus(1'b1, REG_LOG_SEL, 32'h1);
    repeat (2) @(posedge clk_sys);
    bus(1'b0, REG_LOG0, 32'h0);
    chk("older stamp", {31'h0, rd < s0}, 32'h1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic wrap_up();
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h0;
    avs_writedata = 32'h0;
    blk_req = 1'b0;
    meas_in = 32'sd0;
    grp_in = 3'h5;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_regs();
    s_trip();
    s_block();
    s_release();
    s_mode();
    s_evcfg();
    s_log();
    wrap_up();
  end

  // Whole run needs roughly 2500 clocks
  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    wrap_up();
  end
endmodule

bind prog_stage prog_stage_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .start_o(start_o), .trip_o(trip_o),
  .blocked_o(blocked_o), .evt_valid(evt_valid), .evt_code(evt_code));
